// >>> logic/ecc_sdp_pkg.sv
// Shared constants, carrier types and Hamming code functions for the protected memory.
package ecc_sdp_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int ADDR_W = 9;
  localparam int DEPTH = 512;

  // Check bits needed for a given user data width.
  function automatic int check_bits_for(input int width);
    if (width <= 4)
    begin
      return 4;
    end
    else if (width <= 11)
    begin
      return 5;
    end
    else if (width <= 26)
    begin
      return 6;
    end
    else if (width <= 57)
    begin
      return 7;
    end
    return 8;
  endfunction

  localparam int CHECK_W = check_bits_for(DATA_W);
  localparam int SYN_W = CHECK_W - 1;
  localparam int CODE_W = DATA_W + CHECK_W;

  // ----------------------------------------------------------------
  // Error injection positions (data bit indices, codeword position)
  // ----------------------------------------------------------------
  localparam int HARD_INJ_BIT_A = 30;
  localparam int HARD_INJ_BIT_B = 62;
  localparam int SOFT_INJ_DATA_BIT = 0;
  localparam int SOFT_INJ_CHECK_POS = 1;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ERR_ADDR_OFS = 8'h08;
  localparam logic [4:0] CTRL_RESET = 5'h0c;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hard_ecc_option;
    logic double_inject_enable;
    logic single_inject_enable;
    logic soft_ecc_output_stage_enable;
    logic soft_ecc_input_stage_enable;
  } ctrl_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic inject_single;
    logic inject_double;
  } wr_req_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic single_err;
    logic double_err;
    logic [ADDR_W-1:0] err_addr;
  } rd_rsp_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic single_err;
    logic double_err;
  } dec_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [1:0] seen;
    logic [ADDR_W-1:0] last_err_addr;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic stg_wr_en;
    logic [ADDR_W-1:0] stg_wr_addr;
    logic [CODE_W-1:0] stg_wr_code;
    logic stg_rd_en;
    logic [ADDR_W-1:0] stg_rd_addr;
    logic p1_valid;
    logic [ADDR_W-1:0] p1_addr;
    rd_rsp_t mid;
    rd_rsp_t out;
  } top_state_t;

  // ----------------------------------------------------------------
  // Extended Hamming code: bit 0 overall parity, powers of two check bits
  // ----------------------------------------------------------------
  // Codeword position of data bit j.
  function automatic int data_pos(input int j);
    int n;
    n = 0;
    for (int p = 1; p < CODE_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (n == j)
        begin
          return p;
        end
        n++;
      end
    end
    return 0;
  endfunction

  function automatic logic [CODE_W-1:0] encode(input logic [DATA_W-1:0] d);
    logic [CODE_W-1:0] cw;
    logic par;
    int j;
    cw = '0;
    j = 0;
    for (int p = 1; p < CODE_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < SYN_W; k++)
    begin
      par = 1'b0;
      for (int p = 1; p < CODE_W; p++)
      begin
        if ((p & (1 << k)) != 0)
        begin
          par = par ^ cw[p];
        end
      end
      cw[1 << k] = par;
    end
    cw[0] = ^cw[CODE_W-1:1];
    return cw;
  endfunction

  function automatic dec_t decode(input logic [CODE_W-1:0] cw_in);
    logic [CODE_W-1:0] cw;
    logic [SYN_W-1:0] syn;
    logic par;
    dec_t r;
    int j;
    cw = cw_in;
    syn = '0;
    r = '0;
    j = 0;
    for (int p = 1; p < CODE_W; p++)
    begin
      if (cw[p])
      begin
        syn = syn ^ SYN_W'(p);
      end
    end
    par = ^cw;
    if (syn != '0 && par && int'(syn) < CODE_W)
    begin
      cw[syn] = ~cw[syn];
      r.single_err = 1'b1;
    end
    else if (syn != '0)
    begin
      r.double_err = 1'b1;
    end
    else if (par)
    begin
      r.single_err = 1'b1;
    end
    for (int p = 1; p < CODE_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        r.data[j] = cw[p];
        j++;
      end
    end
    return r;
  endfunction

endpackage

// >>> logic/sdp_ram.sv
// Simple dual-port code word memory with a registered read-first output.
`timescale 1ns/1ps

module sdp_ram (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // Write port.
  input wire logic we_in,
  input wire logic [ecc_sdp_pkg::ADDR_W-1:0] waddr_in,
  input wire logic [ecc_sdp_pkg::CODE_W-1:0] wdata_in,
  // Read port.
  input wire logic re_in,
  input wire logic [ecc_sdp_pkg::ADDR_W-1:0] raddr_in,
  output logic [ecc_sdp_pkg::CODE_W-1:0] rdata_out
);

  logic [ecc_sdp_pkg::CODE_W-1:0] mem [ecc_sdp_pkg::DEPTH];
  logic [ecc_sdp_pkg::CODE_W-1:0] rdata_q;
  logic [ecc_sdp_pkg::CODE_W-1:0] rdata_d;

  // Read data holds its value while no read is requested.
  always_comb
  begin
    rdata_d = re_in ? mem[raddr_in] : rdata_q;
  end

  // The array itself has no reset and no initial contents.
  always_ff @(posedge mclk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // A same-address read sees the old word, since the array updates after the edge.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

endmodule

// >>> logic/ecc_write_path.sv
// Check bit encoder with optional single or double error injection.
`timescale 1ns/1ps

module ecc_write_path (
  // Write request and configuration.
  input wire ecc_sdp_pkg::wr_req_t wr_in,
  input wire ecc_sdp_pkg::ctrl_t ctrl_in,
  // Encoded, possibly corrupted, code word.
  output logic [ecc_sdp_pkg::CODE_W-1:0] code_out
);

  logic inj_single;
  logic inj_double;

  // Disabled injection pins are forced low here.
  assign inj_single = wr_in.inject_single & ctrl_in.single_inject_enable;
  assign inj_double = wr_in.inject_double & ctrl_in.double_inject_enable;

  // Encode, then flip the chosen bits; double injection takes precedence.
  always_comb
  begin
    code_out = ecc_sdp_pkg::encode(wr_in.data);
    if (inj_double)
    begin
      if (ctrl_in.hard_ecc_option)
      begin
        code_out[ecc_sdp_pkg::data_pos(ecc_sdp_pkg::HARD_INJ_BIT_A)] ^= 1'b1;
        code_out[ecc_sdp_pkg::data_pos(ecc_sdp_pkg::HARD_INJ_BIT_B)] ^= 1'b1;
      end
      else
      begin
        code_out[ecc_sdp_pkg::data_pos(ecc_sdp_pkg::SOFT_INJ_DATA_BIT)] ^= 1'b1;
        code_out[ecc_sdp_pkg::SOFT_INJ_CHECK_POS] ^= 1'b1;
      end
    end
    else if (inj_single)
    begin
      if (ctrl_in.hard_ecc_option)
      begin
        code_out[ecc_sdp_pkg::data_pos(ecc_sdp_pkg::HARD_INJ_BIT_A)] ^= 1'b1;
      end
      else
      begin
        code_out[ecc_sdp_pkg::data_pos(ecc_sdp_pkg::SOFT_INJ_DATA_BIT)] ^= 1'b1;
      end
    end
  end

endmodule

// >>> logic/ecc_simple_dual_port_ram.sv
// Error-correcting simple dual-port memory with an AHB-Lite control slave.
`timescale 1ns/1ps

module ecc_simple_dual_port_ram (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_in,
  // AHB-Lite slave.
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Memory write port.
  input wire ecc_sdp_pkg::wr_req_t wr_req_in,
  // Memory read port.
  input wire ecc_sdp_pkg::rd_req_t rd_req_in,
  output ecc_sdp_pkg::rd_rsp_t rd_rsp_out
);

  // ----------------------------------------------------------------
  // State and internal nets
  // ----------------------------------------------------------------
  ecc_sdp_pkg::top_state_t s_q;
  ecc_sdp_pkg::top_state_t s_d;
  logic [ecc_sdp_pkg::CODE_W-1:0] wr_code;
  logic mem_we;
  logic [ecc_sdp_pkg::ADDR_W-1:0] mem_waddr;
  logic [ecc_sdp_pkg::CODE_W-1:0] mem_wdata;
  logic mem_re;
  logic [ecc_sdp_pkg::ADDR_W-1:0] mem_raddr;
  logic [ecc_sdp_pkg::CODE_W-1:0] mem_rdata;
  ecc_sdp_pkg::dec_t dec;
  ecc_sdp_pkg::rd_rsp_t rsp;
  logic [1:0] seen_clr;
  logic addr_hit;

  // ----------------------------------------------------------------
  // Encoder and storage
  // ----------------------------------------------------------------
  // One 512 by 64 protected unit covers the whole depth and width.
  ecc_write_path u_write_path (
    .wr_in(wr_req_in),
    .ctrl_in(s_q.ctrl),
    .code_out(wr_code)
  );

  sdp_ram u_ram (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .re_in(mem_re),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  // Port selection: straight from the user or through the input stage.
  always_comb
  begin
    if (s_q.ctrl.soft_ecc_input_stage_enable)
    begin
      mem_we = s_q.stg_wr_en;
      mem_waddr = s_q.stg_wr_addr;
      mem_wdata = s_q.stg_wr_code;
      mem_re = s_q.stg_rd_en;
      mem_raddr = s_q.stg_rd_addr;
    end
    else
    begin
      mem_we = wr_req_in.en;
      mem_waddr = wr_req_in.addr;
      mem_wdata = wr_code;
      mem_re = rd_req_in.en;
      mem_raddr = rd_req_in.addr;
    end
  end

  // Decode the stored word; the array is never written back.
  always_comb
  begin
    dec = ecc_sdp_pkg::decode(mem_rdata);
    rsp.valid = s_q.p1_valid;
    rsp.data = dec.data;
    rsp.single_err = s_q.p1_valid & dec.single_err;
    rsp.double_err = s_q.p1_valid & dec.double_err;
    rsp.err_addr = s_q.p1_addr;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus slave, pipeline stages and sticky error bits.
  always_comb
  begin
    s_d = s_q;
    seen_clr = 2'h0;
    s_d.hreadyout = 1'b1;
    s_d.hresp = 1'b0;
    // Data phase of a write sets the control word or clears the sticky bits written as one; other offsets ignore it.
    if (s_q.ph_valid && s_q.ph_write)
    begin
      case (s_q.ph_addr)
        ecc_sdp_pkg::CTRL_OFS:
        begin
          s_d.ctrl = ecc_sdp_pkg::ctrl_t'(hwdata_in[4:0]);
        end
        ecc_sdp_pkg::STATUS_OFS:
        begin
          seen_clr = hwdata_in[1:0];
        end
        default:
        begin
          seen_clr = 2'h0;
        end
      endcase
    end
    // Input stage always samples; it is only used when enabled.
    s_d.stg_wr_en = wr_req_in.en;
    s_d.stg_wr_addr = wr_req_in.addr;
    s_d.stg_wr_code = wr_code;
    s_d.stg_rd_en = rd_req_in.en;
    s_d.stg_rd_addr = rd_req_in.addr;
    // Track the read in flight through the memory register.
    s_d.p1_valid = mem_re;
    s_d.p1_addr = mem_raddr;
    // Flags and address travel with the data through the output stages.
    s_d.mid = rsp;
    if (s_q.ctrl.soft_ecc_output_stage_enable)
    begin
      s_d.out = s_q.mid;
    end
    else
    begin
      s_d.out = rsp;
    end
    // A new event beats a clear in the same cycle.
    s_d.seen = (s_q.seen & ~seen_clr) | {s_d.out.double_err, s_d.out.single_err};
    if (s_d.out.single_err || s_d.out.double_err)
    begin
      s_d.last_err_addr = s_d.out.err_addr;
    end
    // Address phase of a new transfer.
    addr_hit = haddr_in[31:8] == 24'h000000;
    s_d.ph_valid = hsel_in && hready_in && (htrans_in == ecc_sdp_pkg::HTRANS_NONSEQ);
    s_d.ph_write = hwrite_in;
    s_d.ph_addr = addr_hit ? haddr_in[7:0] : 8'hff;
    s_d.hrdata = 32'h00000000;
    if (s_d.ph_valid && !hwrite_in)
    begin
      case (s_d.ph_addr)
        ecc_sdp_pkg::CTRL_OFS:
        begin
          s_d.hrdata = {27'h0000000, s_d.ctrl};
        end
        ecc_sdp_pkg::STATUS_OFS:
        begin
          s_d.hrdata = {30'h00000000, s_d.seen};
        end
        ecc_sdp_pkg::ERR_ADDR_OFS:
        begin
          s_d.hrdata = {23'h000000, s_d.last_err_addr};
        end
        default:
        begin
          s_d.hrdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Stages are off after reset and the bus is ready.
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
      s_q.ctrl <= ecc_sdp_pkg::CTRL_RESET;
      s_q.hreadyout <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign hrdata_out = s_q.hrdata;
  assign hreadyout_out = s_q.hreadyout;
  assign hresp_out = s_q.hresp;
  assign rd_rsp_out = s_q.out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // The stored word of a clean write decodes to the same data with no flag.
  a_encode_clean: assert property (
    (wr_req_in.en && !wr_req_in.inject_single && !wr_req_in.inject_double)
    |-> (ecc_sdp_pkg::decode(wr_code).data == wr_req_in.data
         && !ecc_sdp_pkg::decode(wr_code).single_err && !ecc_sdp_pkg::decode(wr_code).double_err))
    else $error("clean write does not decode cleanly");

  // A single injection is corrected on decode.
  a_single_fixed: assert property (
    (wr_req_in.en && wr_req_in.inject_single && !wr_req_in.inject_double && s_q.ctrl.single_inject_enable)
    |-> (ecc_sdp_pkg::decode(wr_code).single_err && ecc_sdp_pkg::decode(wr_code).data == wr_req_in.data))
    else $error("single injection not corrected");

  // Both injections together give only the double flag.
  a_double_wins: assert property (
    (wr_req_in.en && wr_req_in.inject_single && wr_req_in.inject_double && s_q.ctrl.double_inject_enable)
    |-> (ecc_sdp_pkg::decode(wr_code).double_err && !ecc_sdp_pkg::decode(wr_code).single_err))
    else $error("double injection did not take precedence");

  // Never both flags for one read.
  a_flags_exclusive: assert property (
    !(rd_rsp_out.single_err && rd_rsp_out.double_err))
    else $error("single and double flags raised together");

  // With no stages the answer comes two edges after the request.
  a_read_latency: assert property (
    (rd_req_in.en && !s_q.ctrl.soft_ecc_input_stage_enable && !s_q.ctrl.soft_ecc_output_stage_enable)
    ##1 (!s_q.ctrl.soft_ecc_output_stage_enable) |-> ##1 rd_rsp_out.valid)
    else $error("read data not valid two cycles after request");

  // The error address is the address of that same read.
  a_err_addr_match: assert property (
    (rd_req_in.en && !s_q.ctrl.soft_ecc_input_stage_enable && !s_q.ctrl.soft_ecc_output_stage_enable)
    ##1 (!s_q.ctrl.soft_ecc_output_stage_enable) |-> ##1 (rd_rsp_out.err_addr == $past(rd_req_in.addr, 2)))
    else $error("error address does not match the read address");

  // A flag only rides on valid data and sets its sticky bit.
  a_flags_with_valid: assert property (
    (rd_rsp_out.single_err || rd_rsp_out.double_err) |-> (rd_rsp_out.valid && s_q.seen != 2'h0))
    else $error("error flag without valid read data or sticky bit");

  // The array is written only for a user write, never to repair a word.
  a_no_writeback: assert property (
    mem_we |-> (wr_req_in.en || $past(wr_req_in.en)))
    else $error("memory written without a user write");

  // The slave never inserts wait states or error responses.
  a_bus_okay: assert property (
    hreadyout_out && !hresp_out)
    else $error("bus slave stalled or answered with an error");

  // The input stage adds one cycle to the read path.
  a_input_stage_lat: assert property (
    (rd_req_in.en && s_q.ctrl.soft_ecc_input_stage_enable && !s_q.ctrl.soft_ecc_output_stage_enable)
    ##1 (s_q.ctrl.soft_ecc_input_stage_enable && !s_q.ctrl.soft_ecc_output_stage_enable)
    ##1 (!s_q.ctrl.soft_ecc_output_stage_enable) |-> ##1 rd_rsp_out.valid)
    else $error("staged read data not valid three cycles after request");

  // With both stages on, the answer comes four edges after the request.
  a_both_stage_lat: assert property (
    (rd_req_in.en && s_q.ctrl.soft_ecc_input_stage_enable && s_q.ctrl.soft_ecc_output_stage_enable)
    ##1 (s_q.ctrl.soft_ecc_input_stage_enable && s_q.ctrl.soft_ecc_output_stage_enable)
    ##1 s_q.ctrl.soft_ecc_output_stage_enable ##1 s_q.ctrl.soft_ecc_output_stage_enable
    |-> ##1 rd_rsp_out.valid)
    else $error("doubly staged read data not valid four cycles after request");

  // A write whose injection requests are disabled stores a clean word.
  a_inject_gated: assert property (
    (wr_req_in.en && !(wr_req_in.inject_single && s_q.ctrl.single_inject_enable)
     && !(wr_req_in.inject_double && s_q.ctrl.double_inject_enable))
    |-> (!ecc_sdp_pkg::decode(wr_code).single_err && !ecc_sdp_pkg::decode(wr_code).double_err))
    else $error("disabled injection corrupted the stored word");

  // Hard double injection leaves both hard positions flipped in the raw data.
  a_hard_double_bits: assert property (
    (wr_req_in.en && wr_req_in.inject_double && s_q.ctrl.double_inject_enable && s_q.ctrl.hard_ecc_option)
    |-> (ecc_sdp_pkg::decode(wr_code).data == (wr_req_in.data ^ (64'h1 << ecc_sdp_pkg::HARD_INJ_BIT_A)
         ^ (64'h1 << ecc_sdp_pkg::HARD_INJ_BIT_B))))
    else $error("hard double injection flipped the wrong bits");

  // Soft double injection is detected and leaves one data bit flipped.
  a_soft_double_bits: assert property (
    (wr_req_in.en && wr_req_in.inject_double && s_q.ctrl.double_inject_enable && !s_q.ctrl.hard_ecc_option)
    |-> (ecc_sdp_pkg::decode(wr_code).double_err
         && ecc_sdp_pkg::decode(wr_code).data == (wr_req_in.data ^ (64'h1 << ecc_sdp_pkg::SOFT_INJ_DATA_BIT))))
    else $error("soft double injection flipped the wrong bits");

  // Read data falls back to zero outside a read data phase.
  a_hrdata_idle: assert property (
    !(s_q.ph_valid && !s_q.ph_write) |-> (hrdata_out == 32'h00000000))
    else $error("bus read data not cleared outside a read");

  // The control word changes only through a bus write to it.
  a_ctrl_by_write: assert property (
    !(s_q.ph_valid && s_q.ph_write && s_q.ph_addr == ecc_sdp_pkg::CTRL_OFS) |=> $stable(s_q.ctrl))
    else $error("control word changed without a bus write");

  // The double seen bit falls only through a status write.
  a_seen_kept: assert property (
    (s_q.seen[1] && !(s_q.ph_valid && s_q.ph_write && s_q.ph_addr == ecc_sdp_pkg::STATUS_OFS))
    |=> s_q.seen[1])
    else $error("double seen bit lost without a clear");

  // A flagged read leaves its address in the error address register.
  a_err_addr_kept: assert property (
    (rd_rsp_out.single_err || rd_rsp_out.double_err) |-> (s_q.last_err_addr == rd_rsp_out.err_addr))
    else $error("error address register not updated by a flagged read");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  // Scenarios the bench should reach: both flags, read-first and stages.
  c_single_seen: cover property (rd_rsp_out.single_err);
  c_double_seen: cover property (rd_rsp_out.double_err);
  c_read_first: cover property (wr_req_in.en && rd_req_in.en && wr_req_in.addr == rd_req_in.addr);
  c_staged_read: cover property (s_q.ctrl.soft_ecc_output_stage_enable && rd_rsp_out.valid);
  c_input_staged: cover property (s_q.ctrl.soft_ecc_input_stage_enable && rd_rsp_out.valid);

endmodule

// >>> tb/mem_user_model.sv
// User logic model that drives the memory write and read ports.
`timescale 1ns/1ps

module mem_user_model (
  // Clock.
  input wire logic mclk_in,
  // Memory ports.
  output ecc_sdp_pkg::wr_req_t wr_req_out,
  output ecc_sdp_pkg::rd_req_t rd_req_out,
  input wire ecc_sdp_pkg::rd_rsp_t rd_rsp_in
);
  // Both ports start idle.
  initial
  begin
    wr_req_out = '0;
    rd_req_out = '0;
  end

  // Raises one write strobe, optionally asking for corruption of this word.
  task automatic put_write(input logic [8:0] a, input logic [63:0] d, input logic si, input logic di);
    @(posedge mclk_in);
    wr_req_out <= '{1'b1, a, d, si, di};
  endtask

  // Drops the strobe; stale address and data are inverted so nothing leans on them.
  task automatic wr_release();
    @(posedge mclk_in);
    wr_req_out <= '{1'b0, ~wr_req_out.addr, ~wr_req_out.data, 1'b0, 1'b0};
  endtask

  // One read, optionally with a write to the same address in the same cycle.
  task automatic do_read(input logic [8:0] a, input logic w, input logic [63:0] wd,
      output ecc_sdp_pkg::rd_rsp_t r, output int lat);
    @(posedge mclk_in);
    rd_req_out <= '{1'b1, a};
    if (w)
    begin
      wr_req_out <= '{1'b1, a, wd, 1'b0, 1'b0};
    end
    @(posedge mclk_in);
    rd_req_out <= '{1'b0, ~a};
    wr_req_out <= '{1'b0, ~a, ~wd, 1'b0, 1'b0};
    lat = 0;
    do
    begin
      @(posedge mclk_in);
      lat++;
    end
    while (rd_rsp_in.valid !== 1'b1 && lat < 8);
    r = rd_rsp_in;
  endtask
endmodule

// >>> tb/ecc_simple_dual_port_ram_test.sv
// Self-checking bench for the error-correcting simple dual-port memory.
`timescale 1ns/1ps

module ecc_simple_dual_port_ram_test;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b1;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h0;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  ecc_sdp_pkg::wr_req_t wr_req;
  ecc_sdp_pkg::rd_req_t rd_req;
  ecc_sdp_pkg::rd_rsp_t rd_rsp;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  // Clock of 4 ns period.
  always #2 mclk_in = ~mclk_in;

  ecc_simple_dual_port_ram i_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .wr_req_in(wr_req), .rd_req_in(rd_req), .rd_rsp_out(rd_rsp)
  );

  mem_user_model i_user (
    .mclk_in(mclk_in), .wr_req_out(wr_req), .rd_req_out(rd_req), .rd_rsp_in(rd_rsp)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Counts a comparison and reports a mismatch.
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Address phase, held until hready is sampled high.
  task automatic bus_addr(input logic [7:0] ofs, input logic wr);
    @(posedge mclk_in);
    haddr_in <= {24'h0, ofs};
    hwrite_in <= wr;
    htrans_in <= ecc_sdp_pkg::HTRANS_NONSEQ;
    do @(posedge mclk_in);
    while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
  endtask

  task automatic bus_write(input logic [7:0] ofs, input logic [31:0] d);
    bus_addr(ofs, 1'b1);
    hwdata_in <= d;
    do @(posedge mclk_in);
    while (hreadyout_out !== 1'b1);
  endtask

  task automatic bus_read(input logic [7:0] ofs, output logic [31:0] d);
    bus_addr(ofs, 1'b0);
    do @(posedge mclk_in);
    while (hreadyout_out !== 1'b1);
    d = hrdata_out;
    check("bus response", 64'h0, {63'h0, hresp_out});
  endtask

  function automatic logic [63:0] pat(input logic [8:0] a);
    return {55'h0, a} ^ 64'h5a5a_3c3c_0f0f_a5a5;
  endfunction

  // Reads one word and compares data, flags, address and latency.
  task automatic read_check(input logic [8:0] a, input logic [63:0] d, input logic se, input logic de, input int l);
    ecc_sdp_pkg::rd_rsp_t r;
    int lat;
    i_user.do_read(a, 1'b0, 64'h0, r, lat);
    check("read latency", l, lat);
    check("read data", d, r.data);
    check("single flag", se, r.single_err);
    check("double flag", de, r.double_err);
    check("error address", a, r.err_addr);
  endtask

  // Sets the control word, writes with the given injects, reads back.
  task automatic run_case(input logic [4:0] c, input logic [8:0] a, input logic si, input logic di,
      input logic [63:0] flip, input logic se, input logic de);
    bus_write(8'h00, {27'h0, c});
    i_user.put_write(a, pat(a), si, di);
    i_user.wr_release();
    read_check(a, pat(a) ^ flip, se, de, 2 + c[0] + c[1]);
  endtask

  // Cuts a hang short.
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      final_report();
    end
  end

  // Main sequence.
  initial
  begin
    logic [31:0] v;
    ecc_sdp_pkg::rd_rsp_t r;
    int lat;
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    bus_read(8'h00, v);
    check("ctrl reset", 64'h0c, v);
    bus_read(8'h04, v);
    check("status reset", 64'h0, v);
    bus_write(8'h10, 32'hffff_ffff);
    bus_read(8'h10, v);
    check("unmapped read", 64'h0, v);
    bus_read(8'h00, v);
    check("ctrl kept", 64'h0c, v);
    // Back-to-back writes at both ends of the array.
    i_user.put_write(9'h000, pat(9'h000), 1'b0, 1'b0);
    i_user.put_write(9'h1ff, pat(9'h1ff), 1'b0, 1'b0);
    i_user.wr_release();
    read_check(9'h000, pat(9'h000), 1'b0, 1'b0, 2);
    read_check(9'h1ff, pat(9'h1ff), 1'b0, 1'b0, 2);
    run_case(5'h0c, 9'h011, 1'b0, 1'b0, 64'h0, 1'b0, 1'b0);
    run_case(5'h0c, 9'h022, 1'b1, 1'b0, 64'h0, 1'b1, 1'b0);
    run_case(5'h0c, 9'h033, 1'b0, 1'b1, 64'h1, 1'b0, 1'b1);
    run_case(5'h0c, 9'h044, 1'b1, 1'b1, 64'h1, 1'b0, 1'b1);
    run_case(5'h00, 9'h055, 1'b1, 1'b1, 64'h0, 1'b0, 1'b0);
    run_case(5'h04, 9'h066, 1'b0, 1'b1, 64'h0, 1'b0, 1'b0);
    run_case(5'h08, 9'h077, 1'b1, 1'b0, 64'h0, 1'b0, 1'b0);
    run_case(5'h1c, 9'h088, 1'b1, 1'b0, 64'h0, 1'b1, 1'b0);
    run_case(5'h1c, 9'h099, 1'b0, 1'b1, 64'h4000_0000_4000_0000, 1'b0, 1'b1);
    run_case(5'h0d, 9'h0aa, 1'b0, 1'b0, 64'h0, 1'b0, 1'b0);
    run_case(5'h0e, 9'h0bb, 1'b1, 1'b0, 64'h0, 1'b1, 1'b0);
    run_case(5'h0f, 9'h0cc, 1'b1, 1'b0, 64'h0, 1'b1, 1'b0);
    // The corrected word was never written back.
    read_check(9'h022, pat(9'h022), 1'b1, 1'b0, 4);
    bus_write(8'h00, 32'h0c);
    bus_read(8'h04, v);
    check("status seen", 64'h3, v);
    bus_read(8'h08, v);
    check("error address reg", 64'h022, v);
    bus_write(8'h04, 32'h1);
    bus_read(8'h04, v);
    check("status after clear", 64'h2, v);
    bus_write(8'h04, 32'h2);
    bus_read(8'h04, v);
    check("status cleared", 64'h0, v);
    // Same-cycle read and write of one address returns the old word.
    i_user.put_write(9'h100, pat(9'h100), 1'b0, 1'b0);
    i_user.wr_release();
    i_user.do_read(9'h100, 1'b1, ~pat(9'h100), r, lat);
    check("read first data", pat(9'h100), r.data);
    read_check(9'h100, ~pat(9'h100), 1'b0, 1'b0, 2);
    final_report();
  end
endmodule
